// *** rtl/ttsq_sequencer.sv ***
// trace trigger sequencer with trigger placement
`timescale 1ns/1ps
module ttsq_sequencer (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst,
	// configuration
	input  wire logic                            fullMode,
	input  wire ttsq_pkg::ttsq_place_t           placeMode,
	input  wire logic [ttsq_pkg::PTR_W-1:0]      placeCount,
	input  wire ttsq_pkg::ttsq_pat_t [7:0]       patCfg,
	input  wire ttsq_pkg::ttsq_range_t           rangeCfg,
	// command
	input  wire logic                            cmdValid,
	input  wire ttsq_pkg::ttsq_cmd_t             cmd,
	// trace start and halt, traced bus states
	input  wire logic                            traceStart,
	input  wire logic                            traceHalt,
	input  wire logic                            sampleValid,
	input  wire logic [ttsq_pkg::STATE_W-1:0]    sampleState,
	// trace memory write
	output      logic                            storeStrobe,
	output      logic [ttsq_pkg::STATE_W-1:0]    storeState,
	output      logic                            storeTrigger,
	// status
	output      logic                            triggered,
	output      logic                            traceDone,
	output      logic [2:0]                      seqTerm,
	output      logic [ttsq_pkg::OCC_W-1:0]      occLeft,
	output      logic [3:0]                      termCount
);
	import ttsq_pkg::*;

	typedef struct packed {
		ttsq_trace_t        tr;
		logic [2:0]         cur;
		logic [OCC_W-1:0]   occLeft;
		logic               loadOcc;
		logic [3:0]         termCount;
		logic [2:0]         trigTerm;
		ttsq_qual_t         restart;
		ttsq_qual_t         storeQ;
		logic [PTR_W-1:0]   postLeft;
		logic               storeStrobe;
		logic [STATE_W-1:0] storeState;
		logic               storeTrig;
		logic               triggered;
		logic               done;
	} ttsq_state_t;

	localparam ttsq_state_t STATE_RESET = '{tr: TR_IDLE, cur: TERM_FIRST,
		occLeft: OCC_ONE, loadOcc: 1'b1, termCount: CNT_RESET,
		trigTerm: TRIG_TERM_RST, restart: QUAL_NEVER, storeQ: QUAL_ANY,
		postLeft: POST_START, storeStrobe: 1'b0, storeState: '0,
		storeTrig: 1'b0, triggered: 1'b0, done: 1'b0};

	ttsq_state_t s_reg;
	ttsq_state_t s_next;
	ttsq_term_t  ent;
	logic [8:0]  hits;
	logic        cmdTake;
	logic [OCC_W-1:0] effOcc;
	logic        primM;
	logic        secM;
	logic        stoM;
	logic        brP;
	logic        brS;
	logic [2:0]  destP;
	logic [2:0]  destS;
	logic [2:0]  lastTerm;
	logic        trigNow;

	// ------------------------------------------------------------
	// comparator bank
	// ------------------------------------------------------------
	// patterns and range
	always_comb begin
		for (int i = 0; i < NPAT; i++) begin
			hits[i] = patHit(patCfg[i], sampleState);
		end
		hits[RANGE_BIT] = (sampleState >= rangeCfg.lo)
			&& (sampleState <= rangeCfg.hi);
	end

	// ------------------------------------------------------------
	// term evaluation
	// ------------------------------------------------------------
	// no insert or delete in full mode
	always_comb begin
		unique case (cmd.op)
			OP_INSERT: cmdTake = cmdValid && !fullMode
				&& s_reg.termCount < CNT_MAX
				&& {1'b0, cmd.idx} <= s_reg.termCount;
			OP_DELETE: cmdTake = cmdValid && !fullMode
				&& s_reg.termCount > CNT_ONE
				&& {1'b0, cmd.idx} < s_reg.termCount;
			default:   cmdTake = cmdValid;
		endcase
	end

	assign lastTerm = 3'(s_reg.termCount - CNT_ONE);
	assign effOcc   = s_reg.loadOcc ? ent.occ : s_reg.occLeft;
	assign primM    = sampleValid && qualMatch(ent.prim, hits);
	assign secM     = sampleValid && qualMatch(fullMode ? ent.sec
		: s_reg.restart, hits);
	assign stoM     = sampleValid && qualMatch(fullMode ? ent.sto
		: s_reg.storeQ, hits);
	assign brP      = primM && effOcc <= OCC_ONE;
	assign brS      = secM && !brP;
	assign destP    = fullMode ? ent.primDest : 3'(s_reg.cur + 3'h1);
	assign destS    = fullMode ? ent.secDest : TERM_FIRST;
	assign trigNow  = fullMode
		? ((brP && destP == s_reg.trigTerm) || (brS && destS == s_reg.trigTerm))
		: (brP && s_reg.cur == lastTerm);

	// ------------------------------------------------------------
	// sequencer and placement
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.storeStrobe = 1'b0;
		s_next.storeTrig   = 1'b0;
		if (cmdTake) begin
			unique case (cmd.op)
				OP_INSERT: s_next.termCount = s_reg.termCount + CNT_ONE;
				OP_DELETE: s_next.termCount = s_reg.termCount - CNT_ONE;
				OP_SETUP: begin
					if (fullMode) s_next.trigTerm = TRIG_TERM_RST;
					else s_next.termCount = CNT_RESET;
				end
				OP_STORE:   s_next.storeQ = cmd.term.prim;
				OP_RESTART: s_next.restart = cmd.term.prim;
				OP_TRIGTERM: begin
					if (cmd.idx != TERM_FIRST) s_next.trigTerm = cmd.idx;
				end
				OP_RESET: begin
					s_next.termCount = CNT_RESET;
					s_next.restart   = QUAL_NEVER;
					s_next.storeQ    = QUAL_ANY;
				end
				default: s_next.termCount = s_reg.termCount;
			endcase
		end
		unique case (s_reg.tr)
			TR_IDLE, TR_DONE: begin
				if (traceStart) begin
					s_next.tr        = TR_SEARCH;
					s_next.cur       = TERM_FIRST;
					s_next.loadOcc   = 1'b1;
					s_next.triggered = 1'b0;
					s_next.done      = 1'b0;
					s_next.postLeft  = placePost(placeMode, placeCount);
				end
			end
			TR_SEARCH: begin
				if (stoM || brP || brS) begin
					s_next.storeStrobe = 1'b1;
					s_next.storeState  = sampleState;
				end
				if (brP || brS) begin
					s_next.cur     = brP ? destP : destS;
					s_next.loadOcc = 1'b1;
				end else if (primM) begin
					s_next.occLeft = effOcc - OCC_ONE;
					s_next.loadOcc = 1'b0;
				end
				if (trigNow) begin
					if (!fullMode) s_next.cur = s_reg.cur;
					s_next.triggered   = 1'b1;
					s_next.storeTrig   = 1'b1;
					s_next.storeStrobe = 1'b1;
					s_next.storeState  = sampleState;
					s_next.tr   = (s_reg.postLeft == POST_END) ? TR_DONE : TR_POST;
					s_next.done = (s_reg.postLeft == POST_END);
				end
			end
			TR_POST: begin
				if (stoM) begin
					s_next.storeStrobe = 1'b1;
					s_next.storeState  = sampleState;
					s_next.postLeft    = s_reg.postLeft - PTR_ONE;
					if (s_reg.postLeft == PTR_ONE) begin
						s_next.tr   = TR_DONE;
						s_next.done = 1'b1;
					end
				end
			end
		endcase
		if (traceHalt && (s_reg.tr == TR_SEARCH || s_reg.tr == TR_POST)) begin
			s_next.tr   = TR_DONE;
			s_next.done = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	ttsq_term_mem u_mem (
		.clk     (clk),
		.rst     (rst),
		.cmdTake (cmdTake),
		.cmd     (cmd),
		.rdAddr  (s_next.cur),
		.rdTerm  (ent)
	);

	assign storeStrobe  = s_reg.storeStrobe;
	assign storeState   = s_reg.storeState;
	assign storeTrigger = s_reg.storeTrig;
	assign triggered    = s_reg.triggered;
	assign traceDone    = s_reg.done;
	assign seqTerm      = s_reg.cur;
	assign occLeft      = s_reg.occLeft;
	assign termCount    = s_reg.termCount;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence searchBranchS;
		s_reg.tr == TR_SEARCH && (brP || brS);
	endsequence

	sequence storedS;
		storeStrobe && storeState == $past(sampleState);
	endsequence

	simple_trig_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.tr == TR_SEARCH && !fullMode && brP && s_reg.cur == lastTerm
		|=> triggered && storeTrigger)
		else $error("last term branch did not trigger");

	prim_next_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.tr == TR_SEARCH && !fullMode && brP && s_reg.cur != lastTerm
		|=> seqTerm == $past(s_reg.cur) + 3'h1)
		else $error("primary branch not to next term");

	restart_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.tr == TR_SEARCH && !fullMode && secM && !brP
		|=> seqTerm == TERM_FIRST)
		else $error("global restart did not return to term one");

	full_trig_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.tr == TR_SEARCH && fullMode && brP && destP == s_reg.trigTerm
		|=> storeTrigger && seqTerm == $past(s_reg.trigTerm))
		else $error("entering trigger term did not trigger");

	trig_term_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.trigTerm != TERM_FIRST)
		else $error("first term chosen as trigger term");

	branch_store_a: assert property (@(posedge clk) disable iff (rst)
		searchBranchS |=> storedS)
		else $error("branch state not stored");

	occ_hold_a: assert property (@(posedge clk) disable iff (rst)
		s_reg.tr == TR_SEARCH && primM && effOcc > OCC_ONE && !secM
		|=> seqTerm == $past(s_reg.cur) && occLeft == $past(effOcc) - OCC_ONE)
		else $error("branch taken before occurrence count");

	setup_a: assert property (@(posedge clk) disable iff (rst)
		cmdValid && cmd.op == OP_SETUP && !fullMode
		|=> termCount == CNT_RESET)
		else $error("simple setup did not leave one term");

	reset_seq_a: assert property (@(posedge clk) disable iff (rst)
		cmdValid && cmd.op == OP_RESET
		|=> termCount == CNT_RESET && s_reg.restart == QUAL_NEVER
			&& s_reg.storeQ == QUAL_ANY)
		else $error("sequencer reset not to default");

	full_fixed_a: assert property (@(posedge clk) disable iff (rst)
		fullMode && cmdValid && (cmd.op == OP_INSERT || cmd.op == OP_DELETE)
		|=> $stable(termCount))
		else $error("term count changed in full mode");

	post_end_a: assert property (@(posedge clk) disable iff (rst)
		storeTrigger && $past(s_reg.postLeft) == POST_END |-> traceDone)
		else $error("end placement did not stop at trigger");

endmodule : ttsq_sequencer

// *** rtl/ttsq_pkg.sv ***
// shared constants, types and functions of the trace trigger sequencer
package ttsq_pkg;

	// ------------------------------------------------------------
	// sizes and constants
	// ------------------------------------------------------------
	localparam int TERMS     = 8;
	localparam int NPAT      = 8;
	localparam int RANGE_BIT = 8;
	localparam int STATE_W   = 32;
	localparam int OCC_W     = 16;
	localparam int PTR_W     = 10;

	localparam logic [2:0]       TERM_FIRST   = 3'h0;
	localparam logic [2:0]       TRIG_TERM_RST = 3'h1;
	localparam logic [3:0]       CNT_RESET    = 4'h1;
	localparam logic [3:0]       CNT_MAX      = 4'h8;
	localparam logic [3:0]       CNT_ONE      = 4'h1;
	localparam logic [OCC_W-1:0] OCC_ONE      = 16'h0001;
	localparam logic [PTR_W-1:0] POST_START   = 10'h1FF;
	localparam logic [PTR_W-1:0] POST_CENTER  = 10'h100;
	localparam logic [PTR_W-1:0] POST_END     = 10'h000;
	localparam logic [PTR_W-1:0] PTR_ONE      = 10'h001;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// or of selected hits, inverted when neg: any = neg, never = none
	typedef struct packed {
		logic       neg;
		logic [8:0] sel;
	} ttsq_qual_t;

	localparam ttsq_qual_t QUAL_ANY   = '{neg: 1'b1, sel: 9'h000};
	localparam ttsq_qual_t QUAL_NEVER = '{neg: 1'b0, sel: 9'h000};

	typedef enum logic [1:0] {
		PAT_ANY    = 2'h0,
		PAT_NEVER  = 2'h1,
		PAT_AND_EQ = 2'h2,
		PAT_OR_NE  = 2'h3
	} ttsq_patmode_t;

	// care bit low marks a don't-care digit
	typedef struct packed {
		ttsq_patmode_t      mode;
		logic [STATE_W-1:0] value;
		logic [STATE_W-1:0] care;
	} ttsq_pat_t;

	typedef struct packed {
		logic [STATE_W-1:0] lo;
		logic [STATE_W-1:0] hi;
	} ttsq_range_t;

	typedef struct packed {
		ttsq_qual_t       prim;
		logic [OCC_W-1:0] occ;
		logic [2:0]       primDest;
		ttsq_qual_t       sec;
		logic [2:0]       secDest;
		ttsq_qual_t       sto;
	} ttsq_term_t;

	localparam ttsq_term_t TERM_DEFAULT = '{prim: QUAL_ANY, occ: OCC_ONE,
		primDest: TRIG_TERM_RST, sec: QUAL_NEVER, secDest: TERM_FIRST,
		sto: QUAL_ANY};

	typedef enum logic [2:0] {
		OP_WRITE    = 3'h0,
		OP_INSERT   = 3'h1,
		OP_DELETE   = 3'h2,
		OP_SETUP    = 3'h3,
		OP_STORE    = 3'h4,
		OP_RESTART  = 3'h5,
		OP_TRIGTERM = 3'h6,
		OP_RESET    = 3'h7
	} ttsq_op_t;

	typedef struct packed {
		ttsq_op_t   op;
		logic [2:0] idx;
		ttsq_term_t term;
	} ttsq_cmd_t;

	typedef enum logic [2:0] {
		PL_START  = 3'h0,
		PL_CENTER = 3'h1,
		PL_END    = 3'h2,
		PL_BEFORE = 3'h3,
		PL_AFTER  = 3'h4
	} ttsq_place_t;

	typedef enum logic [1:0] {
		TR_IDLE   = 2'b00,
		TR_SEARCH = 2'b01,
		TR_POST   = 2'b11,
		TR_DONE   = 2'b10
	} ttsq_trace_t;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic qualMatch(ttsq_qual_t q, logic [8:0] hits);
		return q.neg ^ (|(q.sel & hits));
	endfunction : qualMatch

	function automatic logic patHit(ttsq_pat_t p, logic [STATE_W-1:0] st);
		logic diff;
		diff = |((st ^ p.value) & p.care);
		unique case (p.mode)
			PAT_ANY:    return 1'b1;
			PAT_NEVER:  return 1'b0;
			PAT_AND_EQ: return !diff;
			PAT_OR_NE:  return diff;
		endcase
	endfunction : patHit

	function automatic logic [PTR_W-1:0] placePost(ttsq_place_t m,
			logic [PTR_W-1:0] cnt);
		unique case (m)
			PL_CENTER: return POST_CENTER;
			PL_END:    return POST_END;
			PL_BEFORE: return (cnt >= POST_START) ? POST_END : POST_START - cnt;
			PL_AFTER:  return (cnt >= POST_START) ? POST_START : cnt;
			default:   return POST_START;
		endcase
	endfunction : placePost

endpackage : ttsq_pkg

// *** rtl/ttsq_term_mem.sv ***
// sequence term table with insert, delete and registered read
`timescale 1ns/1ps
module ttsq_term_mem (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// command
	input  wire logic                cmdTake,
	input  wire ttsq_pkg::ttsq_cmd_t cmd,
	// read port
	input  wire logic [2:0]          rdAddr,
	output      ttsq_pkg::ttsq_term_t rdTerm
);
	import ttsq_pkg::*;

	typedef struct packed {
		ttsq_term_t [TERMS-1:0] ent;
		ttsq_term_t             rd;
	} ttsq_mem_t;

	ttsq_mem_t s_reg;
	ttsq_mem_t s_next;

	// ------------------------------------------------------------
	// table update
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (cmdTake) begin
			unique case (cmd.op)
				OP_WRITE: s_next.ent[cmd.idx] = cmd.term;
				OP_INSERT: begin
					for (int i = TERMS - 1; i > 0; i--) begin
						if (i > int'(cmd.idx)) s_next.ent[i] = s_reg.ent[i-1];
					end
					s_next.ent[cmd.idx] = TERM_DEFAULT;
				end
				OP_DELETE: begin
					for (int i = 0; i < TERMS - 1; i++) begin
						if (i >= int'(cmd.idx)) s_next.ent[i] = s_reg.ent[i+1];
					end
					s_next.ent[TERMS-1] = TERM_DEFAULT;
				end
				OP_SETUP: begin
					s_next.ent[TERM_FIRST].prim     = cmd.term.prim;
					s_next.ent[TERM_FIRST].primDest = TRIG_TERM_RST;
				end
				OP_STORE: begin
					for (int i = 0; i < TERMS; i++) begin
						s_next.ent[i].sto = cmd.term.prim;
					end
				end
				OP_RESET: begin
					for (int i = 0; i < TERMS; i++) begin
						s_next.ent[i] = TERM_DEFAULT;
					end
				end
				default: s_next.ent = s_reg.ent;
			endcase
		end
		s_next.rd = s_next.ent[rdAddr];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '{ent: {TERMS{TERM_DEFAULT}}, rd: TERM_DEFAULT};
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdTerm = s_reg.rd;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	insert_new_a: assert property (@(posedge clk) disable iff (rst)
		cmdTake && cmd.op == OP_INSERT
		|=> s_reg.ent[$past(cmd.idx)].prim == QUAL_ANY)
		else $error("inserted term does not match any state");

	delete_shift_a: assert property (@(posedge clk) disable iff (rst)
		cmdTake && cmd.op == OP_DELETE && cmd.idx < 3'h7
		|=> s_reg.ent[$past(cmd.idx)] == $past(s_reg.ent[cmd.idx + 3'h1]))
		else $error("term above deleted one not moved down");

endmodule : ttsq_term_mem

// *** tb/ttsq_bus_model.sv ***
// captured bus state source standing in for the traced processor bus
`timescale 1ns/1ps
module ttsq_bus_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// pacing: one idle cycle between states
	input  wire logic        slow,
	// captured states
	output      logic        sampleValid,
	output      logic [31:0] sampleState
);
	logic [31:0] q[$];
	logic        gap;

	task automatic push(logic [31:0] v);
		q.push_back(v);
	endtask : push

	// ------------------------------------------------------------
	// state stream, scrambled when idle
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sampleValid <= 1'b0;
			sampleState <= 32'h0;
			gap         <= 1'b0;
		end else if (q.size() != 0 && !gap) begin
			sampleValid <= 1'b1;
			sampleState <= q.pop_front();
			gap         <= slow;
		end else begin
			sampleValid <= 1'b0;
			sampleState <= ~sampleState;
			gap         <= 1'b0;
		end
	end
endmodule : ttsq_bus_model

// *** tb/ttsq_sequencer_tb.sv ***
// self-checking bench of the trace trigger sequencer
`timescale 1ns/1ps
module ttsq_sequencer_tb;
	import ttsq_pkg::*;

	localparam ttsq_qual_t Q1 = '{neg: 1'b0, sel: 9'h001};
	localparam ttsq_qual_t Q2 = '{neg: 1'b0, sel: 9'h002};
	localparam ttsq_qual_t Q3 = '{neg: 1'b0, sel: 9'h004};
	localparam ttsq_qual_t QR = '{neg: 1'b0, sel: 9'h100};
	localparam ttsq_qual_t QD = '{neg: 1'b0, sel: 9'h008};
	localparam ttsq_qual_t QN = '{neg: 1'b1, sel: 9'h010};

	logic                    clk, rst, fullMode, cmdValid, slow;
	logic                    traceStart, traceHalt, sampleValid;
	ttsq_place_t             placeMode;
	logic [PTR_W-1:0]        placeCount;
	ttsq_pat_t [7:0]         patCfg;
	ttsq_range_t             rangeCfg;
	ttsq_cmd_t               cmd;
	logic [STATE_W-1:0]      sampleState, storeState;
	logic                    storeStrobe, storeTrigger, triggered, traceDone;
	logic [2:0]              seqTerm;
	logic [OCC_W-1:0]        occLeft;
	logic [3:0]              termCount;
	logic [32:0]             got[$];
	logic [32:0]             e[$];
	int                      num_errors, n_checks;

	ttsq_sequencer DUT (.clk(clk), .rst(rst), .fullMode(fullMode),
		.placeMode(placeMode), .placeCount(placeCount), .patCfg(patCfg),
		.rangeCfg(rangeCfg), .cmdValid(cmdValid), .cmd(cmd),
		.traceStart(traceStart), .traceHalt(traceHalt),
		.sampleValid(sampleValid), .sampleState(sampleState),
		.storeStrobe(storeStrobe), .storeState(storeState),
		.storeTrigger(storeTrigger), .triggered(triggered),
		.traceDone(traceDone), .seqTerm(seqTerm), .occLeft(occLeft),
		.termCount(termCount));

	ttsq_bus_model bus (.clk(clk), .rst(rst), .slow(slow),
		.sampleValid(sampleValid), .sampleState(sampleState));

	// ------------------------------------------------------------
	// clock, store monitor, watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (storeStrobe === 1'b1) got.push_back({storeTrigger, storeState});
	end

	initial begin
		#(40 * 20000);
		num_errors++;
		finish_test();
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(string name, logic [32:0] exp, logic [32:0] act);
		n_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, act);
		end
	endtask : chk

	function automatic ttsq_term_t tq(ttsq_qual_t p, logic [15:0] o = 16'h0001,
			logic [2:0] d = 3'h1, ttsq_qual_t s = QUAL_NEVER,
			logic [2:0] sd = 3'h0);
		return '{prim: p, occ: o, primDest: d, sec: s, secDest: sd,
			sto: QUAL_NEVER};
	endfunction : tq

	task automatic cmd_send(ttsq_op_t op, logic [2:0] idx, ttsq_term_t t);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmd      <= '{op: op, idx: idx, term: t};
		@(posedge clk);
		cmdValid <= 1'b0;
		@(posedge clk);
	endtask : cmd_send

	task automatic run(ttsq_place_t pm, logic [31:0] st[$]);
		int k;
		placeMode  <= pm;
		got.delete();
		@(posedge clk);
		traceStart <= 1'b1;
		@(posedge clk);
		traceStart <= 1'b0;
		@(posedge clk);
		foreach (st[i]) bus.push(st[i]);
		k = 0;
		while (traceDone !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		chk("traceDone", 33'h1, {32'h0, traceDone});
		repeat (20) @(posedge clk);
	endtask : run

	task automatic cmp_list();
		chk("store count", 33'(e.size()), 33'(got.size()));
		foreach (e[i]) if (i < got.size()) chk("stored", e[i], got[i]);
	endtask : cmp_list

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] s[$];
		rst = 1'b1; fullMode = 1'b0; cmdValid = 1'b0; slow = 1'b0;
		traceStart = 1'b0; traceHalt = 1'b0; placeMode = PL_START;
		placeCount = 10'h000; cmd = '0; num_errors = 0; n_checks = 0;
		rangeCfg = '{lo: 32'h0000_0500, hi: 32'h0000_05FF};
		for (int i = 0; i < 8; i++) patCfg[i] = '{PAT_NEVER, 32'h0, 32'h0};
		patCfg[0] = '{PAT_AND_EQ, 32'h0000_0443, 32'hFFFF_FFFF};
		patCfg[1] = '{PAT_AND_EQ, 32'h0000_05C2, 32'hFFFF_FFFF};
		patCfg[2] = '{PAT_AND_EQ, 32'h0000_040F, 32'hFFFF_FFFF};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("seqTerm", 33'h0, 33'(seqTerm));
		chk("occLeft", 33'h1, 33'(occLeft));
		chk("termCount", 33'h1, 33'(termCount));
		chk("triggered", 33'h0, 33'(triggered));
		// default: trigger on first state, placed at start
		for (int i = 0; i < 520; i++) s.push_back(32'h0000_1000 + 32'(i));
		e.delete();
		for (int i = 0; i < 512; i++) e.push_back({i == 0, s[i]});
		run(PL_START, s);
		cmp_list();
		// two-term search with restart, only branch states stored
		cmd_send(OP_SETUP, 3'h0, tq(Q1));
		chk("termCount", 33'h1, 33'(termCount));
		cmd_send(OP_INSERT, 3'h1, tq(QUAL_ANY));
		chk("termCount", 33'h2, 33'(termCount));
		cmd_send(OP_WRITE, 3'h1, tq(Q2));
		cmd_send(OP_INSERT, 3'h1, tq(QUAL_ANY));
		cmd_send(OP_INSERT, 3'h5, tq(QUAL_ANY));
		chk("termCount", 33'h3, 33'(termCount));
		cmd_send(OP_DELETE, 3'h1, tq(QUAL_ANY));
		chk("termCount", 33'h2, 33'(termCount));
		cmd_send(OP_RESTART, 3'h0, tq(Q3));
		cmd_send(OP_STORE, 3'h0, tq(QUAL_NEVER));
		run(PL_END, '{32'h443, 32'h40F, 32'h5C2, 32'h443, 32'h5C2});
		e = '{{1'b0, 32'h443}, {1'b0, 32'h40F}, {1'b0, 32'h443},
			{1'b1, 32'h5C2}};
		cmp_list();
		chk("seqTerm", 33'h1, 33'(seqTerm));
		// full configuration: fixed terms, setup, programmable branches
		fullMode <= 1'b1;
		cmd_send(OP_RESET, 3'h0, tq(QUAL_ANY));
		cmd_send(OP_INSERT, 3'h1, tq(QUAL_ANY));
		chk("termCount", 33'h1, 33'(termCount));
		cmd_send(OP_SETUP, 3'h0, tq(Q1));
		cmd_send(OP_STORE, 3'h0, tq(QUAL_NEVER));
		run(PL_END, '{32'h5C2, 32'h443});
		e = '{{1'b1, 32'h443}};
		cmp_list();
		chk("seqTerm", 33'h1, 33'(seqTerm));
		cmd_send(OP_WRITE, 3'h0, tq(Q1, 16'h0002, 3'h3, Q3, 3'h0));
		cmd_send(OP_WRITE, 3'h3, tq(Q2, 16'h0001, 3'h2));
		cmd_send(OP_TRIGTERM, 3'h2, tq(QUAL_ANY));
		cmd_send(OP_TRIGTERM, 3'h0, tq(QUAL_ANY));
		slow <= 1'b1;
		run(PL_END, '{32'h443, 32'h40F, 32'h443, 32'h443, 32'h5C2});
		e = '{{1'b0, 32'h40F}, {1'b0, 32'h443}, {1'b1, 32'h5C2}};
		cmp_list();
		chk("seqTerm", 33'h2, 33'(seqTerm));
		// simple again: center placement of the default trace
		fullMode  <= 1'b0;
		slow      <= 1'b0;
		patCfg[3] <= '{PAT_AND_EQ, 32'h0000_0400, 32'hFFFF_FF00};
		patCfg[4] <= '{PAT_OR_NE, 32'h0000_1000, 32'hFFFF_FFFF};
		cmd_send(OP_RESET, 3'h0, tq(QUAL_ANY));
		s.delete();
		for (int i = 0; i < 260; i++) s.push_back(32'h0000_2000 + 32'(i));
		e.delete();
		for (int i = 0; i < 257; i++) e.push_back({i == 0, s[i]});
		run(PL_CENTER, s);
		cmp_list();
		// range trigger, don't-care store, counted placement
		cmd_send(OP_SETUP, 3'h0, tq(QR));
		cmd_send(OP_STORE, 3'h0, tq(QD));
		placeCount <= 10'h003;
		s = '{32'h443, 32'h1000, 32'h5C2, 32'h40F, 32'h2000, 32'h411,
			32'h4FF, 32'h400};
		run(PL_AFTER, s);
		e = '{{1'b0, 32'h443}, {1'b1, 32'h5C2}, {1'b0, 32'h40F},
			{1'b0, 32'h411}, {1'b0, 32'h4FF}};
		cmp_list();
		placeCount <= 10'h1FD;
		run(PL_BEFORE, s);
		e = e[0:3];
		cmp_list();
		// halted search never triggers; inverted not-equal pattern triggers on the equal state
		cmd_send(OP_SETUP, 3'h0, tq(QN));
		@(posedge clk);
		traceStart <= 1'b1;
		@(posedge clk);
		traceStart <= 1'b0;
		bus.push(32'h0000_2000);
		repeat (4) @(posedge clk);
		traceHalt <= 1'b1;
		@(posedge clk);
		traceHalt <= 1'b0;
		@(posedge clk);
		chk("halt traceDone", 33'h1, 33'(traceDone));
		chk("halt triggered", 33'h0, 33'(triggered));
		run(PL_END, '{32'h2001, 32'h1000});
		e = '{{1'b1, 32'h1000}};
		cmp_list();
		chk("triggered", 33'h1, 33'(triggered));
		finish_test();
	end
endmodule : ttsq_sequencer_tb
